// *** src/fbcod_defines.svh ***
// Purpose: Constants for the opcode decoder
// Assumes: 10-bit instruction words
// Notes:   Field positions and fixed codes
`ifndef FBCOD_DEFINES_SVH
`define FBCOD_DEFINES_SVH
`define FBCOD_LO_MSB      3
`define FBCOD_HI_LSB      4
`define FBCOD_COL_NOP     6'h00
`define FBCOD_COL_01      6'h01
`define FBCOD_COL_02      6'h02
`define FBCOD_COL_03      6'h03
`define FBCOD_COL_04      6'h04
`define FBCOD_COL_05      6'h05
`define FBCOD_COL_ADDI    6'h06
`define FBCOD_COL_LDI     6'h07
`define FBCOD_COL_PORTIN  6'h26
`define FBCOD_LO_PORT3    4'h3
`define FBCOD_TAG_LONG    2'h2
`define FBCOD_TAG_SEA     6'h07
`define FBCOD_SZD_WORD2   10'h02b
`define FBCOD_PC_RST      14'h0000
`define FBCOD_SP_RST      3'h7
`endif

// *** src/fbcod_pkg.sv ***
// Purpose: Types for the opcode decoder
// Assumes: Defines header is included
// Notes:   Shared by design and bench
package fbcod_pkg;
  typedef enum logic [2:0] {
    FBCOD_FETCH = 3'b001,
    FBCOD_WORD2 = 3'b010,
    FBCOD_KILL  = 3'b100
  } fbcod_state_t;

  typedef enum logic [4:0] {
    FBCOD_OP_NONE, FBCOD_OP_NOP, FBCOD_OP_PDENTRY, FBCOD_OP_SKPDF, FBCOD_OP_JIND,
    FBCOD_OP_CALLIND, FBCOD_OP_IRQOFF, FBCOD_OP_PDCLR, FBCOD_OP_SKPDZ, FBCOD_OP_RET,
    FBCOD_OP_V1A, FBCOD_OP_IRQON, FBCOD_OP_PDSET, FBCOD_OP_SKEQC, FBCOD_OP_RETSK,
    FBCOD_OP_V2A, FBCOD_OP_CCLR, FBCOD_OP_SKEQM, FBCOD_OP_RETI, FBCOD_OP_CLRD,
    FBCOD_OP_SKBIT, FBCOD_OP_ADDI, FBCOD_OP_LDI, FBCOD_OP_TABLE_REF_BY_PAGE, FBCOD_OP_CALLL,
    FBCOD_OP_JMPL, FBCOD_OP_CALLP2, FBCOD_OP_JMPP, FBCOD_OP_ILLEGAL
  } fbcod_op_t;

  typedef struct packed {
    fbcod_op_t   op;
    logic [3:0]  imm;
    logic [5:0]  page;
    logic [6:0]  addr;
    logic [13:0] target;
    logic        twoWord;
    logic        killed;
  } fbcod_dec_t;
endpackage

// *** src/fbcod_decoder.sv ***
// Purpose: Instruction-word decode and skip control
// Assumes: One word per clock from program memory, skipReq from execute
// Notes:   Skip kills the next instruction, no double increment
`timescale 1ns/100ps
`include "fbcod_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Skip invalidates next instruction, same cycles
// - Killed table-ref or return takes one cycle
// - Word: low nibble 3..0, column 9..4
// - Long branch word2: 10, p, a6..a0
// - Indirect branch word2: 10,pp,00,pppp
// - Constant skip word2: 00 0111 nnnn
// - Port D skip word2 fixed pattern
// - Program counter 14 bits, page/address
// - Eight 14-bit return entries, 3-bit index
// - RAM pointer is Z, X, Y
// - Column 00/01 low codes decoded
// - Low nibble 4 decode per column
// - Low nibble 5 decode per column
// - Low nibble 6 decode per column
// - Low nibble 1 decode per column
// - Port 3 input leaves upper acc bits undefined
module fbcod_decoder
  import fbcod_pkg::*;
#(
  parameter int PC_W = 14,
  parameter int SK_D = 8,
  parameter int SP_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [9:0]       instrWord,
  input  wire logic             instrValid,
  input  wire logic             skipReq,
  input  wire logic [1:0]       regZ,
  input  wire logic [3:0]       regX,
  input  wire logic [3:0]       regY,
  output fbcod_dec_t            decOut,
  output logic                  decValid,
  output logic                  wordError,
  output logic [PC_W-1:0]       program_counter,
  output logic [SP_W-1:0]       return_stack_index,
  output logic [9:0]            ram_pointer
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic fbcod_op_t decodeOp(input logic [5:0] col, input logic [3:0] lo);
    fbcod_op_t r;
    r = FBCOD_OP_ILLEGAL;
    unique case (col)
      `FBCOD_COL_NOP: begin
        unique case (lo)
          4'h0: r = FBCOD_OP_NOP;
          4'h2: r = FBCOD_OP_PDENTRY;
          4'h3: r = FBCOD_OP_SKPDF;
          4'h4: r = FBCOD_OP_IRQOFF;
          4'h5: r = FBCOD_OP_IRQON;
          4'h6: r = FBCOD_OP_CCLR;
          default: r = FBCOD_OP_ILLEGAL;
        endcase
      end
      `FBCOD_COL_01: begin
        unique case (lo)
          4'h0: r = FBCOD_OP_JIND;
          4'h1: r = FBCOD_OP_CLRD;
          4'h4: r = FBCOD_OP_PDCLR;
          4'h5: r = FBCOD_OP_PDSET;
          default: r = FBCOD_OP_ILLEGAL;
        endcase
      end
      `FBCOD_COL_02: begin
        unique case (lo)
          4'h0, 4'h1, 4'h2, 4'h3: r = FBCOD_OP_SKBIT;
          4'h4: r = FBCOD_OP_SKPDZ;
          4'h5: r = FBCOD_OP_SKEQC;
          4'h6: r = FBCOD_OP_SKEQM;
          default: r = FBCOD_OP_ILLEGAL;
        endcase
      end
      `FBCOD_COL_03: r = (lo == 4'h0) ? FBCOD_OP_CALLIND : FBCOD_OP_ILLEGAL;
      `FBCOD_COL_04: begin
        unique case (lo)
          4'h4: r = FBCOD_OP_RET;
          4'h5: r = FBCOD_OP_RETSK;
          4'h6: r = FBCOD_OP_RETI;
          default: r = FBCOD_OP_ILLEGAL;
        endcase
      end
      `FBCOD_COL_05: begin
        unique case (lo)
          4'h4: r = FBCOD_OP_V1A;
          4'h5: r = FBCOD_OP_V2A;
          default: r = FBCOD_OP_NONE;   // Other transfers not decoded here
        endcase
      end
      `FBCOD_COL_ADDI: r = FBCOD_OP_ADDI;
      `FBCOD_COL_LDI:  r = FBCOD_OP_LDI;
      default: begin
        // Port 3 input: upper acc bits are left to execute, nothing decoded here
        if (col == `FBCOD_COL_PORTIN && lo == `FBCOD_LO_PORT3) r = FBCOD_OP_NONE;
        else if (col[5:2] == 4'h2) r = FBCOD_OP_TABLE_REF_BY_PAGE;
        else if (col[5:1] == 5'h06) r = FBCOD_OP_CALLL;
        else if (col[5:1] == 5'h07) r = FBCOD_OP_JMPL;
        else if (col[5:3] == 3'h2) r = FBCOD_OP_CALLP2;
        else if (col[5:3] == 3'h3) r = FBCOD_OP_JMPP;
        else                        r = FBCOD_OP_NONE;
      end
    endcase
    return r;
  endfunction

  function automatic logic isTwoWord(input fbcod_op_t op);
    return op inside {FBCOD_OP_JIND, FBCOD_OP_CALLIND, FBCOD_OP_CALLL, FBCOD_OP_JMPL,
                      FBCOD_OP_SKEQC, FBCOD_OP_SKPDZ};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  fbcod_state_t          state_ff, nxt_state;
  fbcod_dec_t            dec_ff, nxt_dec;
  logic                  valid_ff, nxt_valid;
  logic                  err_ff, nxt_err;
  logic [PC_W-1:0]       pc_ff, nxt_pc;
  logic [SP_W-1:0]       sp_ff, nxt_sp;
  logic [9:0]            dp_ff, nxt_dp;
  logic [PC_W-1:0]       stack_ff [SK_D];
  logic [PC_W-1:0]       nxt_stack [SK_D];
  logic [5:0]            col;
  logic [3:0]            lo;
  fbcod_op_t             curOp;
  logic [13:0]           w2Target;
  logic                  w2Ok;
  logic                  skipNow;
  logic                  killNow;

  assign lo    = instrWord[`FBCOD_LO_MSB:0];
  assign col   = instrWord[9:`FBCOD_HI_LSB];
  assign curOp = decodeOp(col, lo);

  // Skip of the reported instruction kills the word taken at this edge
  assign skipNow = valid_ff && skipReq && !dec_ff.killed;
  assign killNow = skipNow || (state_ff == FBCOD_KILL);

  always_comb begin
    nxt_state = state_ff;
    nxt_dec   = dec_ff;
    nxt_valid = 1'b0;
    nxt_err   = 1'b0;
    nxt_pc    = pc_ff;
    nxt_sp    = sp_ff;
    nxt_dp    = {regZ, regX, regY};
    nxt_stack = stack_ff;
    w2Target  = '0;
    w2Ok      = 1'b1;
    if (instrValid) begin
      nxt_pc = pc_ff + 14'h0001;                        // never double-step
      unique case (state_ff)
        FBCOD_FETCH, FBCOD_KILL: begin
          nxt_dec.op      = curOp;
          nxt_dec.imm     = lo;
          nxt_dec.page    = {col[1:0], lo};
          nxt_dec.addr    = instrWord[6:0];
          nxt_dec.target  = {pc_ff[13:7], instrWord[6:0]};
          nxt_dec.twoWord = isTwoWord(curOp);
          nxt_dec.killed  = killNow;
          if (isTwoWord(curOp)) begin
            nxt_state = FBCOD_WORD2;
          end else begin
            nxt_valid = 1'b1;
            // One killed cycle for table-ref and returns too
            nxt_state = FBCOD_FETCH;
            if (!killNow) begin
              if (curOp inside {FBCOD_OP_RET, FBCOD_OP_RETSK, FBCOD_OP_RETI}) begin
                nxt_pc = stack_ff[sp_ff];
                nxt_sp = sp_ff - 3'h1;
              end else if (curOp == FBCOD_OP_JMPP) begin
                nxt_pc = {pc_ff[13:7], instrWord[6:0]};
              end else if (curOp == FBCOD_OP_CALLP2) begin
                nxt_sp = sp_ff + 3'h1;
                nxt_stack[sp_ff + 3'h1] = pc_ff + 14'h0001;
                nxt_pc = {7'h02, instrWord[6:0]};
              end
            end
          end
        end
        FBCOD_WORD2: begin
          unique case (dec_ff.op)
            FBCOD_OP_JMPL, FBCOD_OP_CALLL: begin
              w2Ok     = instrWord[9:8] == `FBCOD_TAG_LONG;
              w2Target = {dec_ff.addr[5:4], dec_ff.imm, instrWord[7], instrWord[6:0]};
              nxt_dec.addr = instrWord[6:0];
            end
            FBCOD_OP_JIND, FBCOD_OP_CALLIND: begin
              w2Ok     = instrWord[9:8] == `FBCOD_TAG_LONG && instrWord[5:4] == 2'b00;
              // Six-bit page sits under a zero top bit; address is regY with three zero bits above
              w2Target = {1'b0, instrWord[7:6], instrWord[3:0], 3'h0, regY};
              nxt_dec.page = {instrWord[7:6], instrWord[3:0]};
            end
            FBCOD_OP_SKEQC: begin
              w2Ok = instrWord[9:4] == `FBCOD_TAG_SEA;
              nxt_dec.imm = instrWord[3:0];
            end
            default: w2Ok = instrWord == `FBCOD_SZD_WORD2;
          endcase
          nxt_dec.target = w2Target;
          nxt_valid = 1'b1;
          nxt_err   = ~w2Ok;
          nxt_state = FBCOD_FETCH;
          if (!dec_ff.killed && w2Ok) begin
            if (dec_ff.op inside {FBCOD_OP_CALLL, FBCOD_OP_CALLIND}) begin
              nxt_sp = sp_ff + 3'h1;
              nxt_stack[sp_ff + 3'h1] = pc_ff + 14'h0001;
            end
            if (dec_ff.op inside {FBCOD_OP_JMPL, FBCOD_OP_CALLL,
                                  FBCOD_OP_JIND, FBCOD_OP_CALLIND})
              nxt_pc = w2Target;
          end
        end
        default: nxt_state = FBCOD_FETCH;
      endcase
    end else if (skipNow) begin
      // Gap in fetch: hold the kill for the next word
      nxt_state = FBCOD_KILL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= FBCOD_FETCH;
      dec_ff   <= '0;
      valid_ff <= 1'b0;
      err_ff   <= 1'b0;
      pc_ff    <= `FBCOD_PC_RST;
      sp_ff    <= `FBCOD_SP_RST;
      dp_ff    <= '0;
      for (int i = 0; i < SK_D; i++) stack_ff[i] <= '0;
    end else begin
      state_ff <= nxt_state;
      dec_ff   <= nxt_dec;
      valid_ff <= nxt_valid;
      err_ff   <= nxt_err;
      pc_ff    <= nxt_pc;
      sp_ff    <= nxt_sp;
      dp_ff    <= nxt_dp;
      stack_ff <= nxt_stack;
    end
  end

  assign decOut             = dec_ff;
  assign decValid           = valid_ff;
  assign wordError          = err_ff;
  assign program_counter    = pc_ff;
  assign return_stack_index = sp_ff;
  assign ram_pointer        = dp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  AST_SKIP_KILLS: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff != FBCOD_WORD2 && decValid && skipReq && !decOut.killed
    |=> decOut.killed)
    else $error("Skipped instruction not invalidated");
  AST_PC_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff != FBCOD_WORD2 && killNow
    |=> program_counter == $past(program_counter) + 14'h1)
    else $error("Killed instruction moved pc by more than one");
  AST_KILL_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff != FBCOD_WORD2 && killNow && !isTwoWord(curOp)
    |=> decValid && decOut.killed)
    else $error("Killed one-word instruction took more than one cycle");
  AST_NOP_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && instrWord == 10'h000 |=> decOut.op == FBCOD_OP_NOP)
    else $error("Zero word not decoded as no-op");
  AST_RET_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && instrWord == 10'h044 |=> decOut.op == FBCOD_OP_RET)
    else $error("Return not decoded");
  AST_RETSK_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && instrWord == 10'h045 |=> decOut.op == FBCOD_OP_RETSK)
    else $error("Return-and-skip not decoded");
  AST_SEQM_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && instrWord == 10'h026 |=> decOut.op == FBCOD_OP_SKEQM)
    else $error("Memory compare skip not decoded");
  AST_CLRD_DEC: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && instrWord == 10'h011 |=> decOut.op == FBCOD_OP_CLRD)
    else $error("Port D clear not decoded");
  AST_TWO_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_FETCH && isTwoWord(curOp) |=> !decValid ##1 1'b1)
    else $error("Two-word instruction issued before second word");
  AST_DP_CAT: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ram_pointer == {$past(regZ), $past(regX), $past(regY)})
    else $error("RAM pointer not formed from Z, X, Y");
  AST_LONG_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_WORD2 && dec_ff.op inside {FBCOD_OP_JMPL, FBCOD_OP_CALLL}
    |=> decOut.addr == 7'($past(instrWord)))
    else $error("Long branch address not taken from second word");
  AST_SZD_BAD: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_WORD2 && dec_ff.op == FBCOD_OP_SKPDZ
    && instrWord != `FBCOD_SZD_WORD2 |=> wordError && decValid)
    else $error("Bad port D skip second word not flagged");
  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (!rst_n)
    instrValid && state_ff == FBCOD_WORD2 && !dec_ff.killed && dec_ff.op == FBCOD_OP_CALLL
    && instrWord[9:8] == `FBCOD_TAG_LONG
    |=> return_stack_index == $past(return_stack_index) + 3'h1)
    else $error("Long call did not push the return stack");
endmodule

// *** tb/fbcod_prog_mem.sv ***
// Purpose: Program memory model feeding instruction words
// Assumes: One word per clock while run is high
// Notes:   Idle bus toggles the last word, so it shows again every second idle cycle
`timescale 1ns/100ps
module fbcod_prog_mem (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [5:0] progLen,
  output logic [9:0]      instrWord,
  output logic            instrValid
);
  logic [9:0] mem [0:63];
  logic [5:0] addrFf = 6'h00;
  initial instrWord = 10'h155;
  initial instrValid = 1'b0;
  task automatic put(input logic [5:0] a, input logic [9:0] w);
    mem[a] = w;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (run && addrFf < progLen) begin
      instrWord <= mem[addrFf];
      instrValid <= 1'b1;
      addrFf <= addrFf + 6'h01;
    end else begin
      // Toggle so old data is shown inverted on every odd idle cycle
      instrWord <= ~instrWord;
      instrValid <= 1'b0;
    end
  end
endmodule

// *** tb/four_bit_cpu_opcode_decoder_tb.sv ***
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Program memory model feeds words back to back
// Notes:   Expected decodes queued at load, popped on decValid
`timescale 1ns/100ps
module four_bit_cpu_opcode_decoder_tb;
  import fbcod_pkg::*;
  typedef struct {
    fbcod_op_t  op;
    logic       killed;
    logic       skip;
    logic       two;
    logic [1:0] fld;
    logic [6:0] val;
  } fbcod_note_t;
  localparam logic [9:0] C1 [17] = '{10'h000, 10'h05b, 10'h002, 10'h003, 10'h004, 10'h005,
    10'h006, 10'h011, 10'h014, 10'h015, 10'h021, 10'h026, 10'h044, 10'h045, 10'h046,
    10'h054, 10'h055};
  localparam fbcod_op_t O1 [17] = '{FBCOD_OP_NOP, FBCOD_OP_NONE, FBCOD_OP_PDENTRY,
    FBCOD_OP_SKPDF, FBCOD_OP_IRQOFF, FBCOD_OP_IRQON, FBCOD_OP_CCLR, FBCOD_OP_CLRD,
    FBCOD_OP_PDCLR, FBCOD_OP_PDSET, FBCOD_OP_SKBIT, FBCOD_OP_SKEQM, FBCOD_OP_RET,
    FBCOD_OP_RETSK, FBCOD_OP_RETI, FBCOD_OP_V1A, FBCOD_OP_V2A};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        skipReq = 1'b0;
  logic [1:0]  regZ = 2'h0;
  logic [3:0]  regX = 4'h0;
  logic [3:0]  regY = 4'h0;
  logic [5:0]  progLen = 6'h00;
  logic [5:0]  wp = 6'h00;
  logic [5:0]  col;
  logic [3:0]  nib;
  logic [9:0]  instrWord, ramPtr, expPtr;
  logic        instrValid, decValid, wordError;
  logic        errSeen = 1'b0;
  logic        started = 1'b0;
  logic [13:0] pc;
  logic [2:0]  stkIdx;
  logic [31:0] rnd = 32'hf2ba;
  fbcod_dec_t  dec;
  fbcod_note_t q[$];
  fbcod_note_t nt;
  int          gap = 0;
  int          n_fail = 0;
  int          checked = 0;
  always #10 clk = ~clk;
  fbcod_prog_mem mem_u (.clk, .run, .progLen, .instrWord, .instrValid);
  fbcod_decoder dut_u (.clk, .rst_n, .instrWord, .instrValid, .skipReq, .regZ, .regX, .regY,
    .decOut(dec), .decValid, .wordError, .program_counter(pc), .return_stack_index(stkIdx),
    .ram_pointer(ramPtr));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cmp_op(input fbcod_op_t e, input fbcod_op_t g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] op exp %s got %s", e.name(), g.name());
    end
  endtask
  task automatic cmp_vec(input string nm, input logic [13:0] e, input logic [13:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Words go to memory, the matching decode note to the queue
  task automatic ins(input logic [9:0] w1, w2, input logic two, input fbcod_op_t o,
                     input logic k, s, input logic [1:0] f, input logic [6:0] v);
    mem_u.put(wp, w1);
    wp++;
    if (two) begin
      mem_u.put(wp, w2);
      wp++;
    end
    q.push_back('{o, k, s, two, f, v});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    expPtr = {regZ, regX, regY};
    #1;
    skipReq = 1'b0;
    if (rst_n) begin
      gap++;
      cmp_vec("ram_pointer", 14'(expPtr), 14'(ramPtr));
      if (wordError === 1'b1) begin
        errSeen = 1'b1;
        cmp_vec("wordError early", 14'h0, 14'(q.size()));
      end
      if (decValid === 1'b1 && q.size() > 0) begin
        nt = q.pop_front();
        // Killed cases keep the one-cycle spacing of plain ones, two-word cases take two cycles
        if (started) cmp_vec("gap", nt.two ? 14'h2 : 14'h1, 14'(gap));
        cmp_vec("killed", 14'(nt.killed), 14'(dec.killed));
        cmp_vec("twoWord", 14'(nt.two), 14'(dec.twoWord));
        if (!nt.killed) cmp_op(nt.op, dec.op);
        case (nt.fld)
          2'h1: cmp_vec("imm", 14'(nt.val), 14'(dec.imm));
          2'h2: cmp_vec("page", 14'(nt.val), 14'(dec.page));
          2'h3: cmp_vec("addr", 14'(nt.val), 14'(dec.addr));
          default: ;
        endcase
        gap = 0;
        started = 1'b1;
        skipReq = nt.skip;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // Assigned codes plus unassigned 05b, arm before power-down entry
    for (int i = 0; i < 17; i++) ins(C1[i], 10'h0, 1'b0, O1[i], 0, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      col = 6'(rnd[4:0] % 5'd22);
      col = (col < 6'd6) ? col + 6'd6 : col + 6'd10;
      nib = rnd[11:8];
      if (col < 6'h08) ins({col, nib}, 0, 0, col[0] ? FBCOD_OP_LDI : FBCOD_OP_ADDI, 0, 0, 1,
        7'(nib));
      else if (col < 6'h10) ins({col, nib}, 0, 0, FBCOD_OP_TABLE_REF_BY_PAGE, 0, 0, 2,
        {1'b0, col[1:0], nib});
      else ins({col, nib}, 0, 0, col[3] ? FBCOD_OP_JMPP : FBCOD_OP_CALLP2, 0, 0, 0, 0);
    end
    ins(10'h0e5, 10'h2cd, 1, FBCOD_OP_JMPL, 0, 0, 3, 7'h4d);
    ins(10'h0c3, 10'h215, 1, FBCOD_OP_CALLL, 0, 0, 3, 7'h15);
    ins(10'h010, 10'h2c6, 1, FBCOD_OP_JIND, 0, 0, 2, 7'h36);
    ins(10'h030, 10'h24a, 1, FBCOD_OP_CALLIND, 0, 0, 2, 7'h1a);
    ins(10'h025, 10'h079, 1, FBCOD_OP_SKEQC, 0, 0, 1, 7'h09);
    ins(10'h024, 10'h02b, 1, FBCOD_OP_SKPDZ, 0, 0, 0, 0);
    ins(10'h003, 10'h0, 0, FBCOD_OP_SKPDF, 0, 1, 0, 0);
    ins(10'h044, 10'h0, 0, FBCOD_OP_RET, 1, 0, 0, 0);
    ins(10'h025, 10'h07c, 1, FBCOD_OP_SKEQC, 0, 1, 1, 7'h0c);
    ins(10'h0e1, 10'h2a0, 1, FBCOD_OP_JMPL, 1, 0, 0, 0);
    ins(10'h020, 10'h0, 0, FBCOD_OP_SKBIT, 0, 1, 0, 0);
    ins(10'h085, 10'h0, 0, FBCOD_OP_TABLE_REF_BY_PAGE, 1, 0, 0, 0);
    ins(10'h073, 10'h0, 0, FBCOD_OP_LDI, 0, 0, 1, 7'h03);
    // Bad port D skip second word, expected to flag only
    mem_u.put(wp, 10'h024);
    mem_u.put(wp + 6'h01, 10'h02a);
    progLen = wp + 6'h02;
    repeat (8) @(posedge clk);
    #1;
    cmp_vec("pc reset", 14'h0000, pc);
    cmp_vec("stack index reset", 14'h0007, 14'(stkIdx));
    rst_n = 1'b1;
    run = 1'b1;
    for (int i = 0; i < 300 && !(q.size() == 0 && errSeen); i++) begin
      @(posedge clk);
      #1;
      rnd = xs(rnd);
      {regZ, regX, regY} = rnd[9:0];
    end
    if (q.size() != 0 || !errSeen) begin
      n_fail++;
      $display("[ERR] drain exp empty got %0d left", q.size());
    end
    print_verdict();
  end
endmodule
